// file: rtl/mxs_bridge.sv
// mxibus slave to vmebus converter: decodes remote cycles, runs vme cycles
// assumes all bus pins are asynchronous and pass two flops before use
`timescale 1ns/10ps
module mxs_bridge (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // mxibus slave pins
  input wire logic mxi_as_n_i,
  input wire logic mxi_ds_n_i,
  input wire logic mxi_wr_n_i,
  input wire logic mxi_size_n_i,
  input wire logic [4:0] mxi_am_i,
  input wire logic [31:0] mxi_ad_i,
  output logic [31:0] mxi_ad_o,
  output logic mxi_ad_oe_o,
  input wire logic mxi_par_n_i,
  output logic mxi_par_n_o,
  output logic mxi_par_oe_o,
  output logic mxi_dtack_n_o,
  output logic mxi_dtack_oe_o,
  output logic mxi_berr_n_o,
  output logic mxi_berr_oe_o,
  // vmebus master pins
  output logic vme_breq_o,
  input wire logic vme_bg_n_i,
  output logic [31:0] vme_addr_o,
  output logic [5:0] vme_am_o,
  output logic [31:0] vme_data_o,
  input wire logic [31:0] vme_data_i,
  output logic vme_as_n_o,
  output logic [1:0] vme_ds_n_o,
  output logic vme_lword_n_o,
  output logic vme_write_n_o,
  input wire logic vme_dtack_n_i,
  input wire logic vme_berr_n_i,
  // window and configuration setup
  input wire logic [3:0] win_en_i,
  input wire logic [3:0][31:0] win_base_i,
  input wire logic [3:0][31:0] win_mask_i,
  input wire logic [3:0][1:0] win_space_i,
  input wire logic [7:0] cfg_la_i,
  // mode select seen by local logic
  output logic rmw_conversion_select_o
);
  mxs_pkg::mxs_st_t st_ff, nxt_st;
  logic as2, ds2, wr2, sz2, par2, gnt2, dtk2, ber2;
  logic [4:0] am2;
  logic [31:0] ad2, vd2, step;
  logic [3:0] hit;
  logic cfg_hit, apar, dpar, blkm, rmw_m, own, as_fall;
  logic f_push, f_pop, f_in_ready, f_out_valid;
  logic [31:0] f_dout;
  logic [1:0] dsel;
  logic [15:0] cfg_rd;
  logic [8:0] blk_next;

  // second sync stage is the only one logic reads
  assign as2 = st_ff.as_q[1];
  assign ds2 = st_ff.ds_q[1];
  assign wr2 = st_ff.wr_q[1];
  assign sz2 = st_ff.sz_q[1];
  assign par2 = st_ff.par_q[1];
  assign gnt2 = st_ff.gnt_q[1];
  assign dtk2 = st_ff.dtk_q[1];
  assign ber2 = st_ff.ber_q[1];
  assign am2 = st_ff.am_q[1];
  assign ad2 = st_ff.ad_q[1];
  assign vd2 = st_ff.vd_q[1];
  assign as_fall = st_ff.as_p && !as2;

  // parity over the synced lines; one parity bit covers all 32
  assign apar = ((^{ad2, ~par2}) == mxs_pkg::PAR_ODD);
  assign dpar = apar;

  // cycle kind from the latched modifier
  assign blkm = (st_ff.am[1:0] == 2'h3);
  assign rmw_m = !blkm && !st_ff.rmw_sel;
  assign own = st_ff.breq && !gnt2;

  // address step follows the transfer width
  always_comb begin
    unique case (st_ff.szc)
      mxs_pkg::SZ_BYTE: step = 32'h1;
      mxs_pkg::SZ_WORD: step = 32'h2;
      default: step = 32'h4;
    endcase
  end
  assign blk_next = st_ff.blk + step[8:0];

  // vme strobes: byte 0 on ds1, byte 1 on ds0, big-endian lanes
  always_comb begin
    if (st_ff.szc == mxs_pkg::SZ_BYTE) begin
      dsel = st_ff.cnt[0] ? 2'h2 : 2'h1;
    end else begin
      dsel = 2'h0;
    end
  end

  // window decode runs on the counter, so mid-block entry is seen
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_win
      mxs_win u_win (
        .addr_i(st_ff.cnt),
        .space_i(st_ff.am[4:3]),
        .en_i(win_en_i[gi]),
        .base_i(win_base_i[gi]),
        .mask_i(win_mask_i[gi]),
        .wspace_i(win_space_i[gi]),
        .hit_o(hit[gi])
      );
    end
  endgenerate

  // configuration space: a16, top quarter, logical address slot
  assign cfg_hit = (st_ff.am[4:3] == mxs_pkg::SP_A16) &&
                   (st_ff.cnt[15:14] == mxs_pkg::CFG_TOP) &&
                   (st_ff.cnt[13:6] == cfg_la_i);
  always_comb begin
    unique case (st_ff.cnt[5:1])
      mxs_pkg::CFG_ID_OFS: cfg_rd = mxs_pkg::CFG_ID_VAL;
      mxs_pkg::CFG_CTL_OFS: cfg_rd = {own, 14'h0, st_ff.rmw_sel};
      default: cfg_rd = 16'h0;
    endcase
  end

  // write data waits here; a full fifo stalls the mxibus beat
  mxs_fifo #(
    .W(mxs_pkg::FIFO_W),
    .D(mxs_pkg::FIFO_D)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(f_push),
    .in_ready_o(f_in_ready),
    .in_data_i(ad2),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_dout)
  );

  // main sequencer
  always_comb begin
    nxt_st = st_ff;
    f_push = 1'b0;
    f_pop = 1'b0;
    nxt_st.as_q = {st_ff.as_q[0], mxi_as_n_i};
    nxt_st.ds_q = {st_ff.ds_q[0], mxi_ds_n_i};
    nxt_st.wr_q = {st_ff.wr_q[0], mxi_wr_n_i};
    nxt_st.sz_q = {st_ff.sz_q[0], mxi_size_n_i};
    nxt_st.par_q = {st_ff.par_q[0], mxi_par_n_i};
    nxt_st.gnt_q = {st_ff.gnt_q[0], vme_bg_n_i};
    nxt_st.dtk_q = {st_ff.dtk_q[0], vme_dtack_n_i};
    nxt_st.ber_q = {st_ff.ber_q[0], vme_berr_n_i};
    nxt_st.am_q = {st_ff.am_q[0], mxi_am_i};
    nxt_st.ad_q = {st_ff.ad_q[0], mxi_ad_i};
    nxt_st.vd_q = {st_ff.vd_q[0], vme_data_i};
    nxt_st.as_p = as2;
    unique case (st_ff.st)
      mxs_pkg::S_IDLE: begin
        if (as_fall) begin
          nxt_st.cnt = ad2;
          nxt_st.am = am2;
          if (sz2) begin
            nxt_st.szc = mxs_pkg::SZ_BYTE;
          end else if (ad2[1:0] == 2'h3) begin
            nxt_st.szc = mxs_pkg::SZ_LONG;
          end else begin
            nxt_st.szc = mxs_pkg::SZ_WORD;
          end
          // unknown codes and bad parity are ignored to strobe release
          if (mxs_pkg::mxs_am_ok(am2) && apar) begin
            nxt_st.st = mxs_pkg::S_WDS;
          end else begin
            nxt_st.st = mxs_pkg::S_SKIP;
          end
        end
      end
      mxs_pkg::S_SKIP: begin
        if (as2) begin
          nxt_st.st = mxs_pkg::S_IDLE;
        end
      end
      mxs_pkg::S_WDS: begin
        if (as2) begin
          // strobe released: end any held vme cycle
          nxt_st.vas_n = 1'b1;
          nxt_st.breq = 1'b0;
          nxt_st.blk = mxs_pkg::BLK_RST;
          nxt_st.st = mxs_pkg::S_IDLE;
        end else if (!ds2) begin
          nxt_st.wr = !wr2;
          if (cfg_hit) begin
            nxt_st.st = mxs_pkg::S_ACK;
            if (st_ff.szc == mxs_pkg::SZ_LONG || (!wr2 && !dpar)) begin
              nxt_st.ber_n = 1'b0;
              nxt_st.ber_oe = 1'b1;
            end else begin
              nxt_st.dtk_n = 1'b0;
              nxt_st.dtk_oe = 1'b1;
              if (!wr2) begin
                if (st_ff.cnt[5:1] == mxs_pkg::CFG_CTL_OFS &&
                    (st_ff.szc == mxs_pkg::SZ_WORD || st_ff.cnt[0])) begin
                  nxt_st.rmw_sel = ad2[0];
                end
              end else begin
                nxt_st.ad_o = {16'h0, cfg_rd};
                nxt_st.par_n = ~(mxs_pkg::PAR_ODD ^ (^cfg_rd));
                nxt_st.ad_oe = 1'b1;
                nxt_st.par_oe = 1'b1;
              end
            end
          end else if (|hit) begin
            if (!wr2 && !dpar) begin
              nxt_st.ber_n = 1'b0;
              nxt_st.ber_oe = 1'b1;
              nxt_st.st = mxs_pkg::S_ACK;
            end else if (!wr2) begin
              if (f_in_ready) begin
                f_push = 1'b1;
                nxt_st.st = mxs_pkg::S_ARB;
              end
            end else begin
              nxt_st.st = mxs_pkg::S_ARB;
            end
          end else begin
            nxt_st.st = mxs_pkg::S_PASS;
          end
        end
      end
      mxs_pkg::S_PASS: begin
        // not ours: keep counting, and break any vme block in flight
        nxt_st.vas_n = 1'b1;
        nxt_st.blk = mxs_pkg::BLK_RST;
        if (ds2) begin
          nxt_st.cnt = st_ff.cnt + step;
          nxt_st.st = mxs_pkg::S_WDS;
        end
      end
      mxs_pkg::S_ARB: begin
        nxt_st.breq = 1'b1;
        if (own && (!st_ff.wr || f_out_valid)) begin
          f_pop = st_ff.wr;
          nxt_st.vdata = f_dout;
          nxt_st.vaddr = {st_ff.cnt[31:2],
                          (st_ff.szc == mxs_pkg::SZ_LONG) ?
                          1'b0 : st_ff.cnt[1], 1'b0};
          nxt_st.vam = {st_ff.am[4:3], 1'b1, st_ff.am[2:0]};
          nxt_st.vwr_n = !st_ff.wr;
          nxt_st.vlw_n = (st_ff.szc != mxs_pkg::SZ_LONG);
          nxt_st.vas_n = 1'b0;
          nxt_st.st = mxs_pkg::S_VRUN;
        end
      end
      mxs_pkg::S_VRUN: begin
        // data strobe waits for the last reply to clear through sync
        if (st_ff.vds_n == 2'h3) begin
          if (dtk2 && ber2) begin
            nxt_st.vds_n = dsel;
          end
        end else if (!dtk2 || !ber2) begin
          nxt_st.vds_n = 2'h3;
          nxt_st.st = mxs_pkg::S_ACK;
          if (!ber2) begin
            nxt_st.ber_n = 1'b0;
            nxt_st.ber_oe = 1'b1;
          end else begin
            nxt_st.dtk_n = 1'b0;
            nxt_st.dtk_oe = 1'b1;
          end
          // a bus error carries no data, so the lines stay released
          if (!st_ff.wr && ber2) begin
            nxt_st.ad_o = vd2;
            nxt_st.par_n = ~(mxs_pkg::PAR_ODD ^ (^vd2));
            nxt_st.ad_oe = 1'b1;
            nxt_st.par_oe = 1'b1;
          end
        end
      end
      mxs_pkg::S_ACK: begin
        // hold the answer until the master lets go of the data strobe
        if (ds2) begin
          nxt_st.dtk_n = 1'b1;
          nxt_st.dtk_oe = 1'b0;
          nxt_st.ber_n = 1'b1;
          nxt_st.ber_oe = 1'b0;
          nxt_st.ad_oe = 1'b0;
          nxt_st.par_oe = 1'b0;
          nxt_st.cnt = st_ff.cnt + step;
          nxt_st.st = mxs_pkg::S_WDS;
          if (!st_ff.vas_n) begin
            if (blkm) begin
              if (blk_next >= mxs_pkg::BLK_LIMIT) begin
                nxt_st.vas_n = 1'b1;
                nxt_st.blk = mxs_pkg::BLK_RST;
              end else begin
                nxt_st.blk = blk_next;
              end
            end else if (!rmw_m) begin
              nxt_st.vas_n = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_ff <= mxs_pkg::ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pins straight from the state register
  assign mxi_ad_o = st_ff.ad_o;
  assign mxi_ad_oe_o = st_ff.ad_oe;
  assign mxi_par_n_o = st_ff.par_n;
  assign mxi_par_oe_o = st_ff.par_oe;
  assign mxi_dtack_n_o = st_ff.dtk_n;
  assign mxi_dtack_oe_o = st_ff.dtk_oe;
  assign mxi_berr_n_o = st_ff.ber_n;
  assign mxi_berr_oe_o = st_ff.ber_oe;
  assign vme_breq_o = st_ff.breq;
  assign vme_addr_o = st_ff.vaddr;
  assign vme_am_o = st_ff.vam;
  assign vme_data_o = st_ff.vdata;
  assign vme_as_n_o = st_ff.vas_n;
  assign vme_ds_n_o = st_ff.vds_n;
  assign vme_lword_n_o = st_ff.vlw_n;
  assign vme_write_n_o = st_ff.vwr_n;
  assign rmw_conversion_select_o = st_ff.rmw_sel;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_badpar_noreq: assert property (
    st_ff.st == mxs_pkg::S_SKIP |-> !vme_breq_o)
    else $error("bus requested for an ignored cycle");
  a_am_reject: assert property (
    (st_ff.st == mxs_pkg::S_IDLE && as_fall && !mxs_pkg::mxs_am_ok(am2))
    |=> st_ff.st == mxs_pkg::S_SKIP)
    else $error("unsupported modifier not ignored");
  a_grant_first: assert property (
    $fell(vme_as_n_o) |-> vme_breq_o && $past(gnt2) == 1'b0)
    else $error("vme cycle started without grant");
  a_hold_ack: assert property (
    $fell(mxi_dtack_n_o) |->
    $past(st_ff.st) == mxs_pkg::S_VRUN || $past(cfg_hit))
    else $error("acknowledge before vme finished");
  a_wpar_berr: assert property (
    (st_ff.st == mxs_pkg::S_WDS && !as2 && !ds2 && !cfg_hit && |hit &&
     !wr2 && !dpar) |-> !f_push ##1 (!mxi_berr_n_o && mxi_berr_oe_o))
    else $error("bad write data not refused");
  a_step_size: assert property (
    (st_ff.st == mxs_pkg::S_ACK && ds2) |=>
    st_ff.cnt == $past(st_ff.cnt) + $past(step))
    else $error("address count stepped wrongly");
  a_blk_bound: assert property (
    st_ff.blk < mxs_pkg::BLK_LIMIT)
    else $error("vme block ran past its limit");
  a_rmw_keep: assert property (
    (st_ff.st == mxs_pkg::S_ACK && ds2 && rmw_m && !vme_as_n_o && !as2)
    |=> !vme_as_n_o [*2])
    else $error("rmw cycle split");
  a_single_rel: assert property (
    (st_ff.st == mxs_pkg::S_ACK && ds2 && !blkm && st_ff.rmw_sel)
    |=> vme_as_n_o)
    else $error("single cycle strobe held");
  a_rd_parity: assert property (
    mxi_ad_oe_o |-> mxi_par_oe_o &&
    (^{mxi_ad_o, ~mxi_par_n_o}) == mxs_pkg::PAR_ODD)
    else $error("read parity wrong");
  a_ad_dir: assert property (
    mxi_ad_oe_o |-> !st_ff.wr && !mxi_dtack_n_o)
    else $error("address/data driven outside read answer");

  c_block: cover property (
    blkm && st_ff.st == mxs_pkg::S_ACK ##[1:40] st_ff.st == mxs_pkg::S_ACK);
  c_rmw: cover property (
    rmw_m && !vme_as_n_o && st_ff.st == mxs_pkg::S_ARB);
  c_cfg_read: cover property (cfg_hit && mxi_ad_oe_o);
endmodule

// file: rtl/mxs_pkg.sv
// constants, state and register types for the mxibus slave bridge
// assumes a 10 MHz ref_clk_i and active-low open-collector bus pins
package mxs_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_SKIP, S_WDS, S_PASS, S_ARB, S_VRUN, S_ACK
  } mxs_state_t;

  localparam int CLK_HZ = 10000000;
  localparam int FIFO_W = 32;
  localparam int FIFO_D = 4;
  localparam logic [8:0] BLK_LIMIT = 9'h100;
  localparam logic [8:0] BLK_RST = 9'h000;
  localparam logic PAR_ODD = 1'h1;
  localparam logic RMW_SEL_RST = 1'h0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SP_A16 = 2'h2;
  localparam logic [1:0] CFG_TOP = 2'h3;
  localparam logic [4:0] CFG_ID_OFS = 5'h00;
  localparam logic [4:0] CFG_CTL_OFS = 5'h01;
  // arbitrary identification value
  localparam logic [15:0] CFG_ID_VAL = 16'h5a01;

  // supported a16/a24/a32 codes, bit 3 of the vme code dropped
  function automatic logic mxs_am_ok(input logic [4:0] am);
    unique case (am)
      5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h1a, 5'h19,
      5'h15, 5'h11,
      5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01: mxs_am_ok = 1'b1;
      default: mxs_am_ok = 1'b0;
    endcase
  endfunction

  typedef struct packed {
    logic [1:0] as_q, ds_q, wr_q, sz_q, par_q, gnt_q, dtk_q, ber_q;
    logic [1:0][4:0] am_q;
    logic [1:0][31:0] ad_q, vd_q;
    logic as_p;
    mxs_state_t st;
    logic [31:0] cnt;
    logic [4:0] am;
    logic [1:0] szc;
    logic wr;
    logic [8:0] blk;
    logic rmw_sel;
    logic [31:0] ad_o;
    logic ad_oe, par_n, par_oe, dtk_n, dtk_oe, ber_n, ber_oe;
    logic breq, vas_n, vlw_n, vwr_n;
    logic [1:0] vds_n;
    logic [31:0] vaddr, vdata;
    logic [5:0] vam;
  } mxs_st_t;

  localparam mxs_st_t ST_RST = '{
    as_q: 2'h3, ds_q: 2'h3, wr_q: 2'h3, gnt_q: 2'h3, dtk_q: 2'h3,
    ber_q: 2'h3, as_p: 1'h1, st: S_IDLE, rmw_sel: RMW_SEL_RST,
    blk: BLK_RST, par_n: 1'h1, dtk_n: 1'h1, ber_n: 1'h1, vas_n: 1'h1,
    vlw_n: 1'h1, vwr_n: 1'h1, vds_n: 2'h3, default: '0};
endpackage

// file: rtl/mxs_win.sv
// one inward address window compare
// assumes base/mask/space are steady configuration from the same clock
`timescale 1ns/10ps
module mxs_win (
  // address under test
  input wire logic [31:0] addr_i,
  input wire logic [1:0] space_i,
  // window setup
  input wire logic en_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] mask_i,
  input wire logic [1:0] wspace_i,
  // result
  output logic hit_o
);
  // combinational so a running block count is judged every cycle
  assign hit_o = en_i && (space_i == wspace_i) &&
                 (((addr_i ^ base_i) & mask_i) == 32'h0);
endmodule

// file: rtl/mxs_fifo.sv
// small write-data fifo with valid/ready on both sides
// assumes one clock; push and pop may occur in the same cycle
`timescale 1ns/10ps
module mxs_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp, rp;
    logic [CW-1:0] cnt;
  } mxs_fifo_st_t;
  mxs_fifo_st_t st_ff, nxt_st;
  logic push, pop;

  assign in_ready_o = (st_ff.cnt != CW'(D));
  assign out_valid_o = (st_ff.cnt != '0);
  assign out_data_o = st_ff.mem[st_ff.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // pointers wrap; depth is a power of two
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data_i;
      nxt_st.wp = st_ff.wp + AW'(1);
    end
    if (pop) begin
      nxt_st.rp = st_ff.rp + AW'(1);
    end
    nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: bench/mxs_vme_model.sv
// vme arbiter and target model on the bridge's vme master pins
// assumes strobes are held until dtack is seen; berr_on answers bus error
`timescale 1ns/10ps
module mxs_vme_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // arbitration
  input wire logic breq_i,
  output logic bg_n_o,
  // data transfer
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  input wire logic as_n_i,
  input wire logic [1:0] ds_n_i,
  input wire logic lword_n_i,
  input wire logic write_n_i,
  output logic dtack_n_o,
  output logic berr_n_o
);
  int dly = 1;
  logic berr_on = 1'b0;
  int gdly = 1;
  int cnt, gcnt;
  logic [31:0] mem [logic [31:0]];
  logic [31:0] k, m;
  // grant after gdly cycles; slow settings stretch the bridge's wait
  always @(posedge clk_i) begin
    if (rst_i || !breq_i) begin
      bg_n_o <= 1'b1;
      gcnt <= 0;
    end else if (gcnt >= gdly) begin
      bg_n_o <= 1'b0;
    end else begin
      gcnt <= gcnt + 1;
    end
  end
  // byte lanes merged by data strobes; released data lines toggle
  always @(posedge clk_i) begin
    k = lword_n_i ? {addr_i[31:1], 1'b0} : {addr_i[31:2], 2'h0};
    m = lword_n_i ? {16'h0, {8{!ds_n_i[1]}}, {8{!ds_n_i[0]}}} : '1;
    if (rst_i) begin
      dtack_n_o <= 1'b1;
      berr_n_o <= 1'b1;
      rdata_o <= '0;
    end else if (ds_n_i == 2'h3) begin
      dtack_n_o <= 1'b1;
      berr_n_o <= 1'b1;
      cnt <= 0;
      rdata_o <= ~rdata_o;
    end else if (!as_n_i && dtack_n_o && berr_n_o) begin
      cnt <= cnt + 1;
      // a refused cycle leaves memory untouched
      if (cnt >= dly && berr_on) begin
        berr_n_o <= 1'b0;
      end else if (cnt >= dly) begin
        if (!mem.exists(k)) mem[k] = '0;
        if (!write_n_i) mem[k] = (mem[k] & ~m) | (wdata_i & m);
        rdata_o <= mem[k];
        dtack_n_o <= 1'b0;
      end
    end
  end
endmodule

// file: bench/testbench.sv
// self-checking bench: bench acts as remote mxibus master
// assumes the vme model answers on the bridge's vme pins
`timescale 1ns/10ps
module testbench;
  logic clk, rst, as_n, ds_n, wr_n, sz_n, par_n, ans_q, vas_q, vds_q;
  logic breq_q, ad_oe, po, poe, dk, dkoe, be, beoe, breq, bg_n, vas;
  logic vlw, vwr, vdk, vbe, sel;
  logic [4:0] am, cam;
  logic [31:0] mad, d, ad_o, va, vdo, vdi, cb, m1, bd [3];
  logic [5:0] vam;
  logic [1:0] vds;
  logic [3:0] we;
  logic [3:0][31:0] wb, wm;
  logic [3:0][1:0] ws;
  logic [7:0] la;
  logic [33:0] eq [$];
  logic [31:0] mq [$];
  logic [4:0] tam [4] = '{5'h01, 5'h1d, 5'h15, 5'h11};
  logic [31:0] tad [4] = '{32'h1000_0013, 32'h0020_0044, 32'h4001, 32'h4002};
  logic [1:0] tsz [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  int failures, total_checks, vas_rel, vds_cnt, breq_cnt, i, n;
  // open-collector lines: pulled high unless someone drives low
  wire logic [31:0] ad_w = mad & (ad_oe ? ad_o : '1);
  wire logic par_w = par_n & (poe ? po : 1'b1);
  wire logic dk_w = dkoe ? dk : 1'b1;
  wire logic be_w = beoe ? be : 1'b1;
  wire logic ans = !dk_w || !be_w;

  mxs_bridge dut_u (
    .ref_clk_i(clk), .reset_i(rst), .mxi_as_n_i(as_n), .mxi_ds_n_i(ds_n),
    .mxi_wr_n_i(wr_n), .mxi_size_n_i(sz_n), .mxi_am_i(am), .mxi_ad_i(ad_w),
    .mxi_ad_o(ad_o), .mxi_ad_oe_o(ad_oe), .mxi_par_n_i(par_w),
    .mxi_par_n_o(po), .mxi_par_oe_o(poe), .mxi_dtack_n_o(dk),
    .mxi_dtack_oe_o(dkoe), .mxi_berr_n_o(be), .mxi_berr_oe_o(beoe),
    .vme_breq_o(breq), .vme_bg_n_i(bg_n), .vme_addr_o(va), .vme_am_o(vam),
    .vme_data_o(vdo), .vme_data_i(vdi), .vme_as_n_o(vas), .vme_ds_n_o(vds),
    .vme_lword_n_o(vlw), .vme_write_n_o(vwr), .vme_dtack_n_i(vdk),
    .vme_berr_n_i(vbe), .win_en_i(we), .win_base_i(wb), .win_mask_i(wm),
    .win_space_i(ws), .cfg_la_i(la), .rmw_conversion_select_o(sel));
  mxs_vme_model vme_u (.clk_i(clk), .rst_i(rst), .breq_i(breq),
    .bg_n_o(bg_n), .addr_i(va), .wdata_i(vdo), .rdata_o(vdi), .as_n_i(vas),
    .ds_n_i(vds), .lword_n_i(vlw), .write_n_i(vwr), .dtack_n_o(vdk),
    .berr_n_o(vbe));

  task automatic chk(input logic [33:0] g, e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] msk(input logic [1:0] sz,
                                      input logic [31:0] ad);
    msk = sz == 2'h2 ? 32'hffff_ffff : sz == 2'h1 ? 32'hffff :
          ad[0] ? 32'hff : 32'hff00;
  endfunction
  task automatic ex(input logic b, oe, input logic [31:0] dd, m);
    eq.push_back({b, oe, dd & m});
    mq.push_back(m);
  endtask
  // address phase; parity pin low-true, odd sense over the lines
  task automatic adr(input logic [4:0] a, input logic [31:0] ad,
                     input logic [1:0] sz, input logic bp);
    am = a;
    cam = a;
    mad = ad;
    sz_n = (sz == 2'h0);
    par_n = ^ad ^ bp;
    as_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // one data strobe; a miss is given a short fixed wait then released
  task automatic beat(input logic w, input logic [31:0] dd,
                      input logic bp, hit);
    int k;
    wr_n = !w;
    mad = w ? dd : '1;
    par_n = w ? ^dd ^ bp : 1'b1;
    ds_n = 1'b0;
    for (k = 0; k < (hit ? 600 : 20) && !ans; k++) @(negedge clk);
    if (hit && !ans) begin
      failures++;
      print_verdict();
    end
    chk({33'h0, ans}, {33'h0, hit});
    ds_n = 1'b1;
    mad = '1;
    par_n = 1'b1;
    for (k = 0; k < 20 && ans; k++) @(negedge clk);
    chk({33'h0, ans}, 34'h0);
    repeat (3) @(negedge clk);
  endtask
  task automatic fin();
    as_n = 1'b1;
    mad = '1;
    repeat (6) @(negedge clk);
  endtask
  task automatic one(input logic [4:0] a, input logic [31:0] ad,
                     input logic [1:0] sz, input logic w,
                     input logic [31:0] dd, input logic b);
    adr(a, ad, sz, 1'b0);
    ex(b, !w && !b, dd, (w || b) ? 32'h0 : msk(sz, ad));
    beat(w, dd, 1'b0, 1'b1);
    fin();
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // answers against the oldest note; vme cycle starts and counts
  always @(posedge clk) begin
    ans_q <= ans;
    vas_q <= vas;
    vds_q <= &vds;
    breq_q <= breq;
    if (breq && !breq_q) breq_cnt++;
    if (vas && !vas_q) vas_rel++;
    if (!(&vds) && vds_q) vds_cnt++;
    if (!vas && vas_q) chk({26'h0, breq, bg_n, vam},
      {26'h0, 2'b10, cam[4:3], 1'b1, cam[2:0]});
    if (ans && !ans_q) begin
      if (eq.size() == 0) chk(34'h1, 34'h0);
      else begin
        m1 = mq.pop_front();
        chk({!be_w, ad_oe, ad_o & m1}, eq.pop_front());
      end
      if (ad_oe) chk({33'h0, po}, {33'h0, ^ad_o});
    end
  end
  // main sequence, inputs moved on the falling edge
  initial begin
    rst = 1'b1;
    {as_n, ds_n, wr_n, sz_n, par_n} = 5'h1f;
    am = '0;
    cam = '0;
    mad = '1;
    la = 8'h12;
    we = 4'h7;
    wb = {32'h0, 32'h4000, 32'h0020_0000, 32'h1000_0000};
    wm = {32'h0, 32'hc000, 32'h00ff_0000, 32'hffff_0000};
    ws = {2'h0, 2'h2, 2'h3, 2'h0};
    n = $urandom(32'h9bc3);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    cb = {16'h0, 2'b11, la, 6'h0};
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      one(tam[i], tad[i], tsz[i], 1'b1, d, 1'b0);
      one(tam[i], tad[i], tsz[i], 1'b0, d, 1'b0);
    end
    // vme target refuses: bus error comes back, no data driven
    vme_u.berr_on = 1'b1;
    one(tam[0], tad[0], tsz[0], 1'b0, 32'h0, 1'b1);
    vme_u.berr_on = 1'b0;
    $display("singles done");
    one(5'h15, cb, 2'h1, 1'b0, {16'h0, mxs_pkg::CFG_ID_VAL}, 1'b0);
    one(5'h15, cb | 32'h3, 2'h2, 1'b0, 32'h0, 1'b1);
    $display("config done");
    n = breq_cnt;
    adr(5'h01, 32'h1000_0200, 2'h0, 1'b1);
    beat(1'b1, d, 1'b0, 1'b0);
    fin();
    adr(5'h0a, 32'h1000_0200, 2'h0, 1'b0);
    beat(1'b0, d, 1'b0, 1'b0);
    fin();
    adr(5'h01, 32'h3000_0000, 2'h0, 1'b0);
    beat(1'b1, d, 1'b0, 1'b0);
    fin();
    chk(34'(breq_cnt - n), 34'h0);
    n = vds_cnt;
    adr(5'h01, 32'h1000_0200, 2'h0, 1'b0);
    ex(1'b1, 1'b0, 32'h0, 32'h0);
    beat(1'b1, d, 1'b1, 1'b1);
    fin();
    chk(34'(vds_cnt - n), 34'h0);
    $display("refusals done");
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      one(5'h15, cb + 32'h2, 2'h1, 1'b1, 32'(i), 1'b0);
      chk({33'h0, sel}, 34'(i));
      one(5'h01, 32'h1000_0403 + 32'(i * 256), 2'h2, 1'b1, d, 1'b0);
      n = vas_rel;
      adr(5'h01, 32'h1000_0403 + 32'(i * 256), 2'h2, 1'b0);
      ex(1'b0, 1'b1, d, 32'hffff_ffff);
      beat(1'b0, 32'h0, 1'b0, 1'b1);
      ex(1'b0, 1'b0, 32'h0, 32'h0);
      beat(1'b1, ~d, 1'b0, 1'b1);
      chk({33'h0, vas_rel > n}, 34'(i));
      fin();
    end
    $display("rmw done");
    vme_u.dly = 12;
    vme_u.gdly = 6;
    adr(5'h07, 32'h0fff_ffff, 2'h2, 1'b0);
    beat(1'b1, 32'h0, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) begin
      bd[i] = $urandom;
      ex(1'b0, 1'b0, 32'h0, 32'h0);
      beat(1'b1, bd[i], 1'b0, 1'b1);
    end
    fin();
    for (i = 0; i < 3; i++) begin
      one(5'h01, 32'h1000_0003 + 32'(4 * i), 2'h2, 1'b0, bd[i], 1'b0);
    end
    vme_u.dly = 1;
    vme_u.gdly = 1;
    n = vas_rel;
    adr(5'h07, 32'h1000_1003, 2'h2, 1'b0);
    repeat (66) begin
      ex(1'b0, 1'b0, 32'h0, 32'h0);
      beat(1'b1, $urandom, 1'b0, 1'b1);
    end
    chk(34'(vas_rel - n), 34'h1);
    fin();
    $display("block done");
    // write data path through the fifo: four beats in, read back in order
    d = $urandom;
    adr(5'h01, 32'h1000_0803, 2'h2, 1'b0);
    for (i = 0; i < 4; i++) begin
      ex(1'b0, 1'b0, 32'h0, 32'h0);
      beat(1'b1, d + 32'(i), 1'b0, 1'b1);
    end
    fin();
    adr(5'h01, 32'h1000_0803, 2'h2, 1'b0);
    for (i = 0; i < 4; i++) begin
      ex(1'b0, 1'b1, d + 32'(i), 32'hffff_ffff);
      beat(1'b0, 32'h0, 1'b0, 1'b1);
    end
    fin();
    $display("fifo done");
    print_verdict();
  end
endmodule
